// ===== logic/lars_pkg.sv
// Package of shared constants and types for the linear array readout sequencer.
package lars_pkg;

    // ********************************************************************
    // Array geometry and timing
    // ********************************************************************
    localparam int PIXEL_COUNT = 512;
    localparam int PIX_W = 10;
    localparam int SYNC_STAGES = 2;
    // Length of the end-of-scan low pulse, in master clock periods.
    localparam int DONE_PULSE_PERIODS = 1;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {
        LARS_IDLE,
        LARS_SHIFT,
        LARS_DONE
    } lars_state_t;

    // Sensor-side timing signals derived for the array.
    typedef struct packed {
        logic shiftPulse;
        logic pixelClear;
        logic scanActive;
        logic [PIX_W-1:0] pixelIndex;
    } lars_sensor_t;

    // Synchronised pin levels from the controller.
    typedef struct packed {
        logic masterClk;
        logic start;
        logic integratorClear;
    } lars_pins_t;

endpackage

// ===== logic/lars_sync.sv
// Two-stage synchroniser for the controller's pins and rising-edge finder for the master clock.
module lars_sync (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins and synchronised result.
    input wire lars_pkg::lars_pins_t pinsRaw,
    output lars_pkg::lars_pins_t pinsSync,
    output logic masterClkRise
);

    typedef struct packed {
        lars_pkg::lars_pins_t meta;
        lars_pkg::lars_pins_t stable;
        logic clkPrev;
    } lars_sync_state_t;

    lars_sync_state_t state;
    lars_sync_state_t next_state;

    // The first stage is only read by the second stage, to keep metastability contained.
    always_comb begin
        next_state = state;
        next_state.meta = pinsRaw;
        next_state.stable = state.meta;
        next_state.clkPrev = state.stable.masterClk;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pinsSync = state.stable;
    assign masterClkRise = state.stable.masterClk & ~state.clkPrev;

endmodule

// ===== logic/lars_readout.sv
// Readout sequencer for a linear photodiode array, driven by the master clock pin.

// ************************************************************************
// Readout sequencer
// ************************************************************************
module lars_readout #(
    parameter int PIXELS = lars_pkg::PIXEL_COUNT
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Controller pins, asynchronous to clk.
    input wire logic masterClk,
    input wire logic start,
    input wire logic integrator_clear,
    // Sensor timing outputs.
    output lars_pkg::lars_sensor_t sensor,
    // End-of-scan, active low.
    output logic scan_done_n
);

    // ********************************************************************
    // Pin synchronisation
    // ********************************************************************
    lars_pkg::lars_pins_t pinsRaw;
    lars_pkg::lars_pins_t pins;
    logic clkRise;

    // All three pins share one synchroniser, so start and clear keep the clock's delay.
    assign pinsRaw = '{masterClk: masterClk, start: start, integratorClear: integrator_clear};

    lars_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinsRaw(pinsRaw),
        .pinsSync(pins),
        .masterClkRise(clkRise)
    );

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        lars_pkg::lars_state_t fsm;
        logic [lars_pkg::PIX_W:0] count;
        lars_pkg::lars_sensor_t sensor;
        logic doneN;
    } lars_rd_state_t;

    lars_rd_state_t st;
    lars_rd_state_t next_st;

    localparam logic [lars_pkg::PIX_W:0] LAST_PIX = (lars_pkg::PIX_W + 1)'(PIXELS - 1);
    localparam logic [lars_pkg::PIX_W:0] DONE_LEN =
        (lars_pkg::PIX_W + 1)'(lars_pkg::DONE_PULSE_PERIODS);

    // Every step is gated by a master clock rising edge, so no other pacing input exists.
    always_comb begin
        next_st = st;
        next_st.sensor.shiftPulse = 1'b0;
        next_st.sensor.pixelClear = pins.integratorClear;
        case (st.fsm)
            lars_pkg::LARS_IDLE: begin
                next_st.doneN = 1'b1;
                if (clkRise && pins.start) begin
                    next_st.fsm = lars_pkg::LARS_SHIFT;
                    next_st.count = '0;
                    next_st.sensor.scanActive = 1'b1;
                    next_st.sensor.pixelIndex = '0;
                    next_st.sensor.shiftPulse = 1'b1;
                end
            end
            lars_pkg::LARS_SHIFT: begin
                // Start is not looked at here, so a level held high cannot restart a scan.
                next_st.doneN = 1'b1;
                if (clkRise) begin
                    if (st.count == LAST_PIX) begin
                        next_st.fsm = lars_pkg::LARS_DONE;
                        next_st.count = '0;
                        next_st.sensor.scanActive = 1'b0;
                        next_st.doneN = 1'b0;
                    end else begin
                        next_st.count = st.count + 1'b1;
                        next_st.sensor.pixelIndex = (lars_pkg::PIX_W)'(st.count + 1'b1);
                        next_st.sensor.shiftPulse = 1'b1;
                    end
                end
            end
            lars_pkg::LARS_DONE: begin
                // The low pulse lasts whole master periods so a slow controller sees it.
                next_st.doneN = 1'b0;
                if (clkRise) begin
                    if (st.count + 1'b1 >= DONE_LEN) begin
                        next_st.fsm = lars_pkg::LARS_IDLE;
                        next_st.doneN = 1'b1;
                        next_st.count = '0;
                    end else begin
                        next_st.count = st.count + 1'b1;
                    end
                end
            end
            default: begin
                next_st.fsm = lars_pkg::LARS_IDLE;
                next_st.doneN = 1'b1;
            end
        endcase
    end

    // Reset returns the sequencer to idle with end-of-scan released high.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '{fsm: lars_pkg::LARS_IDLE, count: '0, sensor: '0, doneN: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // Both outputs come straight from the state register, so no glitch reaches a pin.
    assign sensor = st.sensor;
    assign scan_done_n = st.doneN;

    // ********************************************************************
    // Checks
    // ********************************************************************
    // A start seen at a rising master edge while idle opens the scan at pixel zero.
    property p_start_begins;
        @(posedge clk) disable iff (!rst_n)
        (st.fsm == lars_pkg::LARS_IDLE && clkRise && pins.start) |=>
            (sensor.scanActive && sensor.shiftPulse && sensor.pixelIndex == '0);
    endproperty
    a_start_begins: assert property (p_start_begins) else $error("Scan did not start.");

    // Every shift pulse answers a master edge seen one cycle earlier.
    property p_one_pixel;
        @(posedge clk) disable iff (!rst_n)
        sensor.shiftPulse |-> $past(clkRise);
    endproperty
    a_one_pixel: assert property (p_one_pixel) else $error("Shift without clock edge.");

    // A shift pulse lasts one cycle, so no master period is counted twice.
    property p_single_shift;
        @(posedge clk) disable iff (!rst_n)
        sensor.shiftPulse |=> !sensor.shiftPulse;
    endproperty
    a_single_shift: assert property (p_single_shift) else $error("Shift pulse too long.");

    // Each further master edge before the last pixel steps the index by one; a start held high mid-scan
    // must not pull it back to zero.
    property p_index_steps;
        @(posedge clk) disable iff (!rst_n)
        (st.fsm == lars_pkg::LARS_SHIFT && clkRise && st.count != LAST_PIX) |=>
            (sensor.shiftPulse && sensor.pixelIndex == $past(sensor.pixelIndex) + 1'b1);
    endproperty
    a_index_steps: assert property (p_index_steps) else $error("Index did not step.");

    // End-of-scan never drops while pixels are still being shifted.
    property p_high_active;
        @(posedge clk) disable iff (!rst_n)
        sensor.scanActive |-> scan_done_n;
    endproperty
    a_high_active: assert property (p_high_active) else $error("End-of-scan low in scan.");

    // The low pulse comes only straight out of a running scan.
    property p_done_after_scan;
        @(posedge clk) disable iff (!rst_n)
        $fell(scan_done_n) |-> $past(st.fsm) == lars_pkg::LARS_SHIFT;
    endproperty
    a_done_after_scan: assert property (p_done_after_scan) else $error("Stray end pulse.");

    // The scan closes only after the last pixel, and end-of-scan drops with it.
    property p_pulse_after_last;
        @(posedge clk) disable iff (!rst_n)
        $fell(sensor.scanActive) |->
            !scan_done_n && $past(sensor.pixelIndex) == LAST_PIX[lars_pkg::PIX_W-1:0];
    endproperty
    a_pulse_after_last: assert property (p_pulse_after_last) else $error("No end pulse.");

    // The low pulse ends at the master edge that closes its last period.
    property p_pulse_ends;
        @(posedge clk) disable iff (!rst_n)
        (st.fsm == lars_pkg::LARS_DONE && clkRise && st.count == DONE_LEN - 1'b1) |=>
            (scan_done_n && st.fsm == lars_pkg::LARS_IDLE);
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("End pulse too long.");

    // The integrator clear is passed on one cycle after it is synchronised.
    property p_clear_follows;
        @(posedge clk) disable iff (!rst_n)
        pins.integratorClear |=> sensor.pixelClear;
    endproperty
    a_clear_follows: assert property (p_clear_follows) else $error("Clear not passed on.");

    // Releasing the clear releases the sensor line just as quickly.
    property p_clear_drops;
        @(posedge clk) disable iff (!rst_n)
        !pins.integratorClear |=> !sensor.pixelClear;
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("Clear not released.");

    // No shift is made in idle unless start meets a master edge.
    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_n)
        (st.fsm == lars_pkg::LARS_IDLE && !(clkRise && pins.start)) |=> !sensor.shiftPulse;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Shift without start.");

    // Reset leaves every sensor timing line quiet and end-of-scan high.
    property p_reset_idle;
        @(posedge clk)
        !rst_n |=> (scan_done_n && sensor == '0);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("Outputs not idle after reset.");

endmodule

// ===== sim/lars_ctrl_model.sv
// Behavioural model of the front end controller that clocks and starts the sequencer.
module lars_ctrl_model (
    // Bench clock used to place pin changes.
    input wire logic clk,
    // End-of-scan from the sequencer.
    input wire logic scan_done_n,
    // Pixel shift strobe from the sequencer, one per sample to convert.
    input wire logic pixelShift,
    // Pins driven towards the sequencer.
    output logic masterClk,
    output logic start,
    output logic integrator_clear
);
    timeunit 1ns;
    timeprecision 100ps;

    logic sawDone;
    logic [15:0] sampleCount = 16'h0000;

    // Each shifted pixel becomes one 16-bit sample; only their number is kept here.
    always @(posedge clk) if (pixelShift) sampleCount <= sampleCount + 16'h0001;

    // ********************************************************************
    // Pin behaviour
    // ********************************************************************
    // Pins idle low, and the master clock stands still between scans.
    initial begin
        masterClk = 1'b0;
        start = 1'b0;
        integrator_clear = 1'b0;
        sawDone = 1'b0;
    end

    // Remember the end-of-scan pulse so that no new start is raised early.
    always @(negedge scan_done_n) sawDone = 1'b1;

    // One master period is 8 bench clocks, each change just after a bench edge.
    // The rate is far above either variant's limit to keep runs short; the sequencer
    // only counts edges, so its behaviour does not depend on the rate.
    task automatic tick();
        repeat (4) @(posedge clk);
        #2 masterClk = 1'b1;
        repeat (4) @(posedge clk);
        #2 masterClk = 1'b0;
    endtask

    // Start is held over several rising edges, so later ones must be ignored.
    task automatic run_scan(input int holdPeriods);
        int guard;
        guard = 0;
        sawDone = 1'b0;
        @(posedge clk);
        #2 start = 1'b1;
        repeat (holdPeriods) tick();
        start = 1'b0;
        while (!sawDone && guard < 64) begin
            tick();
            guard++;
        end
        // One more period closes the done pulse before any new start is raised.
        tick();
    endtask

    // The integrator clear is a plain level from the controller.
    task automatic set_clear(input logic level);
        @(posedge clk);
        #2 integrator_clear = level;
    endtask
endmodule

// ===== sim/lars_readout_tb.sv
// Self-checking bench for the readout sequencer against a controller model.
module lars_readout_tb;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(what, exp, got) begin totalChecks++; if ((got) !== (exp)) begin numErrors++; $display("MISMATCH %s exp %0h got %0h", what, exp, got); end end

    // A short array keeps each scan to a few microseconds.
    localparam int NPIX = 8;
    logic clk;
    logic rst_n;
    logic masterClk;
    logic start;
    logic integrator_clear;
    logic scan_done_n;
    logic prevDone = 1'b1;
    lars_pkg::lars_sensor_t sensor;
    int numErrors = 0;
    int totalChecks = 0;
    int expIdx, lowCycles, falls, firstShift, doneAt;
    int cyc = 0;

    lars_readout #(.PIXELS(NPIX)) DUT (.clk(clk), .rst_n(rst_n), .masterClk(masterClk),
        .start(start), .integrator_clear(integrator_clear), .sensor(sensor),
        .scan_done_n(scan_done_n));
    lars_ctrl_model CTRL (.clk(clk), .scan_done_n(scan_done_n),
        .pixelShift(sensor.shiftPulse), .masterClk(masterClk),
        .start(start), .integrator_clear(integrator_clear));

    // ********************************************************************
    // Clock, monitor and closing
    // ********************************************************************
    // The bench clock runs at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Watch every shift and every low cycle of end-of-scan, mid-cycle where all is settled.
    always @(negedge clk) begin
        cyc++;
        if (rst_n && sensor.shiftPulse) begin
            `CHK("pixelIndex", expIdx[9:0], sensor.pixelIndex)
            `CHK("doneDuringShift", 1'b1, scan_done_n)
            if (expIdx == 0) firstShift = cyc;
            expIdx++;
        end
        if (rst_n && sensor.scanActive) `CHK("doneWhileActive", 1'b1, scan_done_n)
        if (rst_n && scan_done_n === 1'b0) begin
            lowCycles++;
            if (prevDone === 1'b1) begin
                falls++;
                doneAt = cyc;
            end
        end
        prevDone = scan_done_n;
    end

    task automatic testDone();
        if (numErrors == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A whole run takes well under this span, so reaching it means a hang.
    initial begin
        #100000;
        numErrors++;
        testDone();
    end

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    // One full scan with start held high over three rising master edges.
    task automatic scan_once();
        int samplesBefore;
        samplesBefore = CTRL.sampleCount;
        expIdx = 0;
        lowCycles = 0;
        falls = 0;
        CTRL.run_scan(3);
        repeat (8) @(posedge clk);
        `CHK("shiftCount", NPIX, expIdx)
        `CHK("donePulses", 1, falls)
        `CHK("doneLowCycles", 8, lowCycles)
        `CHK("scanCycles", NPIX * 8, doneAt - firstShift)
        `CHK("samples", NPIX, CTRL.sampleCount - samplesBefore)
    endtask

    // The clear level must reach the sensor side and fall again.
    task automatic clear_check();
        CTRL.set_clear(1'b1);
        repeat (6) @(posedge clk);
        `CHK("pixelClearHigh", 1'b1, sensor.pixelClear)
        CTRL.set_clear(1'b0);
        repeat (6) @(posedge clk);
        `CHK("pixelClearLow", 1'b0, sensor.pixelClear)
    endtask

    // Reset for six cycles, then two scans back to back and a clear.
    initial begin
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        `CHK("idleDone", 1'b1, scan_done_n)
        `CHK("idleSensor", lars_pkg::lars_sensor_t'('0), sensor)
        scan_once();
        scan_once();
        clear_check();
        testDone();
    end
endmodule
